// ===== bce_pkg.sv
// Functional notes
// - select pair picks pin-low, flag set, clear, none
// - derive zero, negative, overflow, carry conditions
// - low nibble is the condition test mask
// - bits four to seven give required states
// - mask ANDed with matches; any bit means met
// - zero+negative mask, zero set tests non-negative
package bce_pkg;

    // ----------------------------------------------------------------
    // field positions inside the eight-bit condition field
    // ----------------------------------------------------------------
    localparam int BCE_MASK_LSB   = 0;     // mask nibble starts here
    localparam int BCE_REQ_LSB    = 4;     // required-state nibble starts here
    localparam int BCE_NIB_W      = 4;     // one bit per accumulator condition

    // bit position of each condition inside a nibble
    localparam int BCE_BIT_ZERO   = 3;     // accumulator equals zero
    localparam int BCE_BIT_NEG    = 2;     // accumulator below zero
    localparam int BCE_BIT_OVF    = 1;     // overflow
    localparam int BCE_BIT_CARRY  = 0;     // carry

    // ----------------------------------------------------------------
    // reset values and defaults
    // ----------------------------------------------------------------
    localparam logic BCE_PIN_RST  = 1'b1;  // pin synchroniser idles high (not asserted)
    localparam logic BCE_MET_RST  = 1'b0;  // registered decision reads not met
    localparam int   BCE_ACC_W    = 32;    // accumulator width
    localparam int   BCE_SYNC_LAT = 2;     // pin to decision latency, cycles

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    // flag select pair of a conditional instruction
    typedef enum logic [1:0] {
        BCE_TP_PIN_LOW  = 2'b00,           // branch input pin low
        BCE_TP_TC_SET   = 2'b01,           // test control flag set
        BCE_TP_TC_CLEAR = 2'b10,           // test control flag clear
        BCE_TP_NONE     = 2'b11            // nothing tested
    } bce_tp_t;

    // accumulator condition nibble, zero in the msb
    typedef struct packed {
        logic zero;
        logic neg;
        logic ovf;
        logic carry;
    } bce_acc_flags_t;

    // eight-bit condition field: required states over mask
    typedef struct packed {
        bce_acc_flags_t req;
        bce_acc_flags_t mask;
    } bce_cond_field_t;

endpackage

// ===== bce_branch_condition_evaluator.sv
module bce_branch_condition_evaluator
    import bce_pkg::*;
#(
    parameter int ACC_W = BCE_ACC_W        // accumulator width
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [ACC_W-1:0] accum_value,
    input  wire logic            overflow_flag,
    input  wire logic            carry_flag,
    input  wire logic            test_control_flag,
    input  wire logic            branch_input_pin,
    input  wire bce_tp_t         flag_select_pair,
    input  wire bce_cond_field_t accum_condition_field,
    output logic                 cond_met,
    output logic                 flag_sel_met,
    output logic                 accum_cond_met,
    output logic                 branch_pin_low_reg,
    output logic                 cond_met_reg
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // a sign bit and at least one magnitude bit are needed
    if (ACC_W < 2) begin : g_bad_width
        $error("accumulator width must be at least two bits");
    end

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic pin_meta_reg;                    // first stage, read only by second
    logic pin_meta_next;
    logic pin_sync_reg;                    // second stage, safe to use
    logic pin_sync_next;
    logic met_next;                        // next registered decision

    // next values: the pin is asynchronous to core_clk
    always_comb begin
        pin_meta_next = branch_input_pin;
        pin_sync_next = pin_meta_reg;
        met_next      = cond_met;
    end

    // registers only; reset loads constants
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta_reg <= BCE_PIN_RST;
            pin_sync_reg <= BCE_PIN_RST;
            cond_met_reg <= BCE_MET_RST;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            cond_met_reg <= met_next;
        end
    end

    // exposes the pin state the decision actually used
    assign branch_pin_low_reg = ~pin_sync_reg;

    // ----------------------------------------------------------------
    // flag select decode
    // ----------------------------------------------------------------
    // pin test costs two cycles of latency; the sequencer must
    // allow for this when software polls the pin in a tight loop
    always_comb begin
        case (flag_select_pair)
            BCE_TP_PIN_LOW:  flag_sel_met = ~pin_sync_reg;
            BCE_TP_TC_SET:   flag_sel_met = test_control_flag;
            BCE_TP_TC_CLEAR: flag_sel_met = ~test_control_flag;
            default:         flag_sel_met = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // accumulator conditions
    // ----------------------------------------------------------------
    bce_acc_flags_t acc_now;               // live conditions
    bce_acc_flags_t match;                 // condition equals required state
    bce_acc_flags_t hits;                  // tested and matching

    always_comb begin
        acc_now.zero  = (accum_value == '0);
        acc_now.neg   = accum_value[ACC_W-1];
        acc_now.ovf   = overflow_flag;
        acc_now.carry = carry_flag;
        // required state sits in the upper nibble
        match = ~(accum_condition_field.req ^ acc_now);
        // low nibble selects which conditions take part
        hits  = accum_condition_field.mask & match;
    end

    // any hit meets the test; a zero mask tests nothing and passes,
    // which keeps flag-only conditional forms usable
    // zero+negative mask with zero=1, neg=0 gives zero OR not negative,
    // which is the non-negative test
    always_comb begin
        if (accum_condition_field.mask == '0) begin
            accum_cond_met = 1'b1;
        end else begin
            accum_cond_met = |hits;
        end
    end

    // ----------------------------------------------------------------
    // final decision
    // ----------------------------------------------------------------
    // no register in the path so the branch decision lands in the
    // same decode cycle; the cost is a longer combinational path
    assign cond_met = flag_sel_met & accum_cond_met;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [1:0] live_cnt_reg;              // cycles since reset, saturating
    logic [1:0] live_cnt_next;             // next value of the live count

    // helper count: pin checks wait until the synchroniser holds real
    // samples, since its reset value is not a sample of the pin
    always_comb begin
        if (live_cnt_reg == 2'h3) begin
            live_cnt_next = live_cnt_reg;      // saturate, never wraps
        end else begin
            live_cnt_next = live_cnt_reg + 2'h1;
        end
    end

    // registers only; reset restarts the count
    always_ff @(posedge core_clk) begin
        if (rst) begin
            live_cnt_reg <= 2'h0;
        end else begin
            live_cnt_reg <= live_cnt_next;
        end
    end

    // pin seen through two flops drives the select-pair decision
    pin_select_a: assert property (
        (live_cnt_reg == 2'h3 && flag_select_pair == BCE_TP_PIN_LOW)
        |-> (flag_sel_met == !$past(branch_input_pin, BCE_SYNC_LAT)))
        else $error("pin select does not follow pin after sync");

    flag_select_a: assert property (
        (flag_select_pair == BCE_TP_TC_CLEAR || flag_select_pair == BCE_TP_TC_SET)
        |-> (flag_sel_met == (test_control_flag == flag_select_pair[0])))
        else $error("flag select decode wrong");

    zero_cond_a: assert property (
        (accum_condition_field.mask == 4'h8 && accum_condition_field.req == 4'h8)
        |-> (accum_cond_met == (accum_value == '0)))
        else $error("zero condition wrong");

    empty_mask_a: assert property (
        (accum_condition_field.mask == 4'h0) |-> accum_cond_met)
        else $error("empty mask must pass");

    neg_state_a: assert property (
        (accum_condition_field.mask == 4'h4)
        |-> (accum_cond_met == (accum_condition_field.req.neg == accum_value[ACC_W-1])))
        else $error("required state ignored");

    any_hit_a: assert property (
        (accum_condition_field.mask == 4'h3 && accum_condition_field.req == 4'h3)
        |-> (accum_cond_met == (overflow_flag || carry_flag)))
        else $error("mask and match not ORed");

    nonneg_test_a: assert property (
        (accum_condition_field.mask == 4'hC && accum_condition_field.req == 4'h8)
        |-> (accum_cond_met == !accum_value[ACC_W-1]))
        else $error("non-negative test wrong");

    same_cycle_a: assert property (
        (flag_select_pair == BCE_TP_NONE && accum_condition_field.mask == 4'h0)
        |-> cond_met ##1 cond_met_reg)
        else $error("decision not same cycle");

    // registered pin view tracks the pin whatever the select pair
    pin_reg_track_a: assert property (
        (live_cnt_reg == 2'h3)
        |-> (branch_pin_low_reg == !$past(branch_input_pin, BCE_SYNC_LAT)))
        else $error("registered pin view does not follow pin");

    // select pair eleven tests nothing, so it always passes
    none_select_a: assert property (
        (flag_select_pair == BCE_TP_NONE) |-> flag_sel_met)
        else $error("none select must pass");

    // overflow alone under test follows its required state
    ovf_cond_a: assert property (
        (accum_condition_field.mask == 4'h2)
        |-> (accum_cond_met == (accum_condition_field.req.ovf == overflow_flag)))
        else $error("overflow condition wrong");

    // carry alone under test follows its required state
    carry_cond_a: assert property (
        (accum_condition_field.mask == 4'h1)
        |-> (accum_cond_met == (accum_condition_field.req.carry == carry_flag)))
        else $error("carry condition wrong");

    // the registered copy trails the live decision by one edge;
    // skipped on the first edge, where it still holds its reset value
    met_reg_follow_a: assert property (
        (live_cnt_reg != 2'h0) |-> (cond_met_reg == $past(cond_met)))
        else $error("registered decision lags wrongly");

    // ----------------------------------------------------------------
    // cover points for the main scenarios
    // ----------------------------------------------------------------

    pin_taken_c: cover property (
        flag_select_pair == BCE_TP_PIN_LOW && cond_met);

    nonneg_taken_c: cover property (
        accum_condition_field.mask == 4'hC && accum_condition_field.req == 4'h8 && cond_met);

    not_met_c: cover property (
        flag_select_pair == BCE_TP_TC_SET && !cond_met);

    // pin released again after a low spell
    pin_release_c: cover property (
        live_cnt_reg == 2'h3 && $fell(branch_pin_low_reg));

    // overflow or carry meets a two-condition mask
    any_hit_c: cover property (
        accum_condition_field.mask == 4'h3 && accum_cond_met);

endmodule // bce_branch_condition_evaluator

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bce_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic                   core_clk, rst;         // clock and sync reset
    logic [BCE_ACC_W-1:0]   accum_value;           // accumulator under test
    logic                   overflow_flag, carry_flag, test_control_flag;
    logic                   branch_input_pin;      // async pin, idles high
    bce_tp_t                flag_select_pair;      // select pair
    bce_cond_field_t        accum_condition_field; // states over mask
    logic                   cond_met, flag_sel_met, accum_cond_met;
    logic                   branch_pin_low_reg, cond_met_reg;
    int                     bad_count, n_compared; // verdict counters
    logic                   pin_low_exp;           // bench view of the pin

    bce_branch_condition_evaluator i_dut (.core_clk(core_clk), .rst(rst), .accum_value(accum_value),
        .overflow_flag(overflow_flag), .carry_flag(carry_flag), .test_control_flag(test_control_flag),
        .branch_input_pin(branch_input_pin), .flag_select_pair(flag_select_pair),
        .accum_condition_field(accum_condition_field), .cond_met(cond_met), .flag_sel_met(flag_sel_met),
        .accum_cond_met(accum_cond_met), .branch_pin_low_reg(branch_pin_low_reg), .cond_met_reg(cond_met_reg));

    // free-running 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // shared checking and stimulus tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // drive one instruction, judge the same cycle and the registered copy
    task automatic apply(input logic [31:0] acc, input logic ov, cy, tc, input bce_tp_t sel, input logic [7:0] fld);
        logic [3:0] act;
        logic       ea, ef;
        act = {acc == 32'h0, acc[31], ov, cy};
        ea  = (fld[3:0] == 4'h0) | (|(fld[3:0] & ~(fld[7:4] ^ act)));
        case (sel)
            BCE_TP_PIN_LOW: ef = pin_low_exp;
            BCE_TP_TC_SET:  ef = tc;
            BCE_TP_TC_CLEAR: ef = ~tc;
            default:        ef = 1'b1;
        endcase
        @(posedge core_clk);
        accum_value <= acc;
        overflow_flag <= ov;
        carry_flag <= cy;
        test_control_flag <= tc;
        flag_select_pair <= sel;
        accum_condition_field <= fld;
        @(negedge core_clk);
        check("flag_sel_met", flag_sel_met, ef);
        check("accum_cond_met", accum_cond_met, ea);
        check("cond_met", cond_met, ef & ea);
        @(negedge core_clk);
        check("cond_met_reg", cond_met_reg, ef & ea);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // flag set, flag clear and none, each with the flag both ways
    task automatic t_select();
        for (int s = 1; s < 4; s++)
            for (int t = 0; t < 2; t++) apply(32'h1, 1'b0, 1'b0, t[0], bce_tp_t'(s), 8'h00);
    endtask

    // every single-condition mask with both required states
    task automatic t_conditions();
        logic [31:0] accs [4] = '{32'h0, 32'h1, 32'hFFFFFFFF, 32'h7FFFFFFF};
        for (int i = 0; i < 4; i++)
            for (int v = 0; v < 2; v++)
                for (int b = 0; b < 4; b++)
                    for (int r = 0; r < 2; r++)
                        apply(accs[i], v[0], ~v[0], 1'b1, BCE_TP_NONE, {4'(r << b), 4'(1 << b)});
    endtask

    // zero-set, negative-clear under a zero+negative mask means non-negative
    task automatic t_nonneg();
        logic [31:0] accs [3] = '{32'h0, 32'h5, 32'hFFFFFFFF};
        for (int i = 0; i < 3; i++) begin
            apply(accs[i], 1'b1, 1'b1, 1'b0, BCE_TP_NONE, 8'h8C);
            check("non_negative", accum_cond_met, ~accs[i][31]);
        end
    endtask

    // overflow and carry both tested for set: either one meets the test
    task automatic t_any_hit();
        for (int k = 0; k < 4; k++) begin
            apply(32'h1, k[1], k[0], 1'b1, BCE_TP_TC_SET, 8'h33);
            check("any_hit", accum_cond_met, k[1] | k[0]);
        end
    endtask

    // pin pulled low reaches the select-pair decision through the synchroniser
    task automatic t_pin();
        int n;
        @(posedge core_clk);
        branch_input_pin <= 1'b0;
        @(negedge core_clk);
        check("pin_early", branch_pin_low_reg, 1'b0);
        n = 0;
        while (branch_pin_low_reg !== 1'b1) begin
            if (n++ == 4) begin
                check("pin_timeout", 1'b0, 1'b1);
                complete_run();
            end
            @(negedge core_clk);
        end
        pin_low_exp = 1'b1;
        apply(32'h1, 1'b0, 1'b0, 1'b0, BCE_TP_PIN_LOW, 8'h01);
        apply(32'h1, 1'b0, 1'b0, 1'b0, BCE_TP_PIN_LOW, 8'h00);
        // release the pin; two flops later the decision sees it high
        @(posedge core_clk);
        branch_input_pin <= 1'b1;
        pin_low_exp = 1'b0;
        repeat (3) @(posedge core_clk);
        apply(32'h1, 1'b0, 1'b0, 1'b0, BCE_TP_PIN_LOW, 8'h00);
        check("pin_release", branch_pin_low_reg, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence: reset, then each scenario
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_compared = 0;
        pin_low_exp = 1'b0;
        rst = 1'b1;
        accum_value = '0;
        overflow_flag = 1'b0;
        carry_flag = 1'b0;
        test_control_flag = 1'b0;
        branch_input_pin = 1'b1;
        flag_select_pair = BCE_TP_PIN_LOW;
        accum_condition_field = 8'h00;
        repeat (7) @(posedge core_clk);
        @(negedge core_clk);
        check("rst_pin_reg", branch_pin_low_reg, 1'b0);
        check("rst_met_reg", cond_met_reg, 1'b0);
        @(posedge core_clk);
        rst <= 1'b0;
        apply(32'h1, 1'b0, 1'b0, 1'b0, BCE_TP_PIN_LOW, 8'h00);
        t_select();
        t_conditions();
        t_nonneg();
        t_any_hit();
        t_pin();
        complete_run();
    end
endmodule // tb
